/* hw/mrs_regs.svh */
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

// ------------------------------------------------------------
// mode register indexes
// ------------------------------------------------------------
`define MRS_IDX_FEATURE1 8'h01
`define MRS_IDX_LATENCY 8'h02
`define MRS_IDX_DRIVE 8'h03
`define MRS_IDX_TEMP 8'h04
`define MRS_IDX_MAKER 8'h05

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MRS_TUF_BIT 7
`define MRS_RATE_HI 2
`define MRS_HOT_BIT 2
`define MRS_BL_LSB 0
`define MRS_BT_BIT 3
`define MRS_WC_BIT 4

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define MRS_LAT_RST 4'h1
`define MRS_DRV_RST 4'h2
`define MRS_BL_RST 3'h2
`define MRS_BL4 3'h2
`define MRS_BL8 3'h3
`define MRS_BL16 3'h4
`define MRS_RATE_RST 3'h3
`define MRS_RATE_COLD 3'h0
`define MRS_RATE_RSVD 3'h4
`define MRS_RATE_HOT 3'h7
// arbitrary neutral maker code
`define MRS_MAKER_ID 8'h5a

`endif

/* hw/mrs_pkg.sv */
package mrs_pkg;

  // mode register command from the command/address decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] mode_reg_index;
    logic [7:0] opcode_bits;
  } mrs_cmd_t;

  // burst request from the column decoder
  typedef struct packed {
    logic start;
    logic [9:0] col;
  } mrs_burst_t;

  // decoded latencies
  typedef struct packed {
    logic [3:0] read_latency;
    logic [2:0] write_latency;
    logic valid;
  } mrs_lat_t;

  typedef enum logic [2:0] {
    MRS_IDLE = 3'b001,
    MRS_RUN = 3'b010,
    MRS_BAD = 3'b100
  } mrs_burst_st_t;

endpackage

/* hw/mrs_lat_dec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrs_regs.svh"

// ------------------------------------------------------------
// latency and drive strength code decoder
// ------------------------------------------------------------
module mrs_lat_dec (
  input wire logic [3:0] lat_code_in,
  input wire logic [3:0] drv_code_in,
  output var mrs_pkg::mrs_lat_t lat_out,
  output logic [6:0] drive_ohm_out,
  output logic drive_valid_out
);

  // read/write latency table, reserved codes flagged invalid
  always_comb begin
    lat_out = '0;
    case (lat_code_in)
      4'h1: lat_out = '{4'h3, 3'h1, 1'b1};
      4'h2: lat_out = '{4'h4, 3'h2, 1'b1};
      4'h3: lat_out = '{4'h5, 3'h2, 1'b1};
      4'h4: lat_out = '{4'h6, 3'h3, 1'b1};
      4'h5: lat_out = '{4'h7, 3'h4, 1'b1};
      4'h6: lat_out = '{4'h8, 3'h4, 1'b1};
      default: lat_out = '0;
    endcase
  end

  // drive strength in whole ohms (34.3 reported as 34)
  always_comb begin
    drive_ohm_out = 7'h00;
    drive_valid_out = 1'b1;
    case (drv_code_in)
      4'h1: drive_ohm_out = 7'h22;
      4'h2: drive_ohm_out = 7'h28;
      4'h3: drive_ohm_out = 7'h30;
      4'h4: drive_ohm_out = 7'h3c;
      4'h6: drive_ohm_out = 7'h50;
      4'h7: drive_ohm_out = 7'h78;
      default: drive_valid_out = 1'b0;
    endcase
  end

endmodule // mrs_lat_dec
`default_nettype wire

/* hw/mrs_burst_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrs_regs.svh"

// ------------------------------------------------------------
// burst column sequencer
// ------------------------------------------------------------
module mrs_burst_seq (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire mrs_pkg::mrs_burst_t burst_in,
  input wire logic [2:0] burst_length_in,
  input wire logic burst_order_in,
  input wire logic wrap_select_in,
  output logic [9:0] col_out,
  output logic col_valid_out,
  output logic illegal_out
);

  logic [9:0] base_r;
  logic [3:0] offs_r;
  logic [3:0] cnt_r;
  logic [3:0] mask_r;
  logic nowrap_r;
  logic order_r;
  mrs_pkg::mrs_burst_st_t st_r;
  logic [3:0] len_mask;
  logic legal;

  // length mask selects 2, 3 or 4 wrapping bits
  always_comb begin
    len_mask = 4'h3;
    legal = 1'b1;
    case (burst_length_in)
      `MRS_BL4: len_mask = 4'h3;
      `MRS_BL8: begin
        len_mask = 4'h7;
        legal = !wrap_select_in;
      end
      `MRS_BL16: begin
        len_mask = 4'hf;
        legal = !wrap_select_in && !burst_order_in;
      end
      default: legal = 1'b0;
    endcase
  end

  // state and counters
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= mrs_pkg::MRS_IDLE;
      base_r <= 10'h000;
      offs_r <= 4'h0;
      cnt_r <= 4'h0;
      mask_r <= 4'h3;
      nowrap_r <= 1'b0;
      order_r <= 1'b0;
    end else begin
      case (st_r)
        mrs_pkg::MRS_IDLE, mrs_pkg::MRS_RUN: begin
          if (burst_in.start) begin
            base_r <= {burst_in.col[9:1], 1'b0};
            offs_r <= {burst_in.col[3:1], 1'b0} & len_mask;
            cnt_r <= 4'h0;
            mask_r <= len_mask;
            nowrap_r <= wrap_select_in;
            order_r <= burst_order_in;
            st_r <= legal ? mrs_pkg::MRS_RUN : mrs_pkg::MRS_BAD;
          end else if (st_r == mrs_pkg::MRS_RUN) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == mask_r) begin
              st_r <= mrs_pkg::MRS_IDLE;
            end
          end
        end
        mrs_pkg::MRS_BAD: st_r <= mrs_pkg::MRS_IDLE;
        default: st_r <= mrs_pkg::MRS_IDLE;
      endcase
    end
  end

  // column of the current beat
  logic [3:0] seq_lo;
  logic [3:0] int_lo;
  always_comb begin
    seq_lo = (offs_r + cnt_r) & mask_r;
    int_lo = (offs_r ^ cnt_r) & mask_r;
    col_out = base_r;
    if (nowrap_r) begin
      col_out = base_r + {6'h00, cnt_r}; // no-wrap walks linearly
    end else begin
      col_out = (base_r & ~{6'h00, mask_r}) |
                {6'h00, (order_r ? int_lo : seq_lo)};
    end
  end

  assign col_valid_out = (st_r == mrs_pkg::MRS_RUN);
  assign illegal_out = (st_r == mrs_pkg::MRS_BAD);

endmodule // mrs_burst_seq
`default_nettype wire

/* hw/mrs_mode_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrs_regs.svh"


// ------------------------------------------------------------
// mode register bank
// ------------------------------------------------------------
module mrs_mode_regs (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire mrs_pkg::mrs_cmd_t cmd_in,
  input wire mrs_pkg::mrs_burst_t burst_in,
  input wire logic [2:0] sensor_rate_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic [9:0] col_out,
  output logic col_valid_out,
  output logic burst_illegal_out,
  output logic [3:0] read_latency_out,
  output logic [2:0] write_latency_out,
  output logic latency_valid_out,
  output logic [6:0] drive_strength_out,
  output logic drive_valid_out,
  output logic derate_out,
  output logic over_85c_out,
  output logic temp_limit_out
);

  // ----------------------------------------------------------
  // register storage
  // ----------------------------------------------------------
  logic [3:0] latency_select_r;
  logic [3:0] drive_strength_r;
  logic [2:0] burst_length_r;
  logic burst_order_r;
  logic wrap_select_r;
  logic [2:0] rate_meta_r;
  logic [2:0] rate_sync_r;
  logic [2:0] rate_r;
  logic temp_update_flag_r;
  logic temp_update_flag_nxt;
  logic [7:0] rd_data_nxt;
  mrs_pkg::mrs_lat_t lat;
  logic [6:0] drv_ohm;
  logic drv_ok;

  // index match helper
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] ref_idx);
    hit = (idx == ref_idx);
  endfunction

  // writes to write-only registers; reserved upper bits dropped
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latency_select_r <= `MRS_LAT_RST;
      drive_strength_r <= `MRS_DRV_RST;
    end else if (cmd_in.wr) begin
      if (hit(cmd_in.mode_reg_index, `MRS_IDX_LATENCY)) begin
        latency_select_r <= cmd_in.opcode_bits[3:0];
      end
      if (hit(cmd_in.mode_reg_index, `MRS_IDX_DRIVE)) begin
        drive_strength_r <= cmd_in.opcode_bits[3:0];
      end
    end
  end

  // feature-1 burst controls
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      burst_length_r <= `MRS_BL_RST;
      burst_order_r <= 1'b0;
      wrap_select_r <= 1'b0;
    end else if (cmd_in.wr && hit(cmd_in.mode_reg_index, `MRS_IDX_FEATURE1)) begin
      burst_length_r <= cmd_in.opcode_bits[`MRS_BL_LSB +: 3];
      burst_order_r <= cmd_in.opcode_bits[`MRS_BT_BIT];
      wrap_select_r <= cmd_in.opcode_bits[`MRS_WC_BIT];
    end
  end

  // sensor rate code synchroniser, then registered value
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rate_meta_r <= `MRS_RATE_RST;
      rate_sync_r <= `MRS_RATE_RST;
      rate_r <= `MRS_RATE_RST;
    end else begin
      rate_meta_r <= sensor_rate_in;
      rate_sync_r <= rate_meta_r;
      // reserved sensor code is not reported
      if (rate_sync_r != `MRS_RATE_RSVD) begin
        rate_r <= rate_sync_r;
      end
    end
  end

  // update flag: change sets, read clears, set wins
  logic rate_change;
  logic temp_read;
  always_comb begin
    rate_change = (rate_sync_r != rate_r) && (rate_sync_r != `MRS_RATE_RSVD);
    temp_read = cmd_in.rd && hit(cmd_in.mode_reg_index, `MRS_IDX_TEMP);
    temp_update_flag_nxt = temp_update_flag_r;
    if (temp_read) begin
      temp_update_flag_nxt = 1'b0;
    end
    if (rate_change) begin
      temp_update_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      temp_update_flag_r <= 1'b0;
    end else begin
      temp_update_flag_r <= temp_update_flag_nxt;
    end
  end

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------
  always_comb begin
    rd_data_nxt = 8'h00;
    if (hit(cmd_in.mode_reg_index, `MRS_IDX_TEMP)) begin
      rd_data_nxt = {temp_update_flag_r, 4'h0, rate_r};
    end else if (hit(cmd_in.mode_reg_index, `MRS_IDX_MAKER)) begin
      rd_data_nxt = `MRS_MAKER_ID;
    end
  end

  // read data registered one cycle after the read command
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= cmd_in.rd;
      if (cmd_in.rd) begin
        rd_data_out <= rd_data_nxt;
      end
    end
  end

  // ----------------------------------------------------------
  // decoders and status outputs
  // ----------------------------------------------------------
  mrs_lat_dec u_lat_dec (
    .lat_code_in(latency_select_r),
    .drv_code_in(drive_strength_r),
    .lat_out(lat),
    .drive_ohm_out(drv_ohm),
    .drive_valid_out(drv_ok)
  );

  // decoded settings held in flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      read_latency_out <= 4'h3;
      write_latency_out <= 3'h1;
      latency_valid_out <= 1'b1;
      drive_strength_out <= 7'h28;
      drive_valid_out <= 1'b1;
      derate_out <= 1'b0;
      over_85c_out <= 1'b0;
      temp_limit_out <= 1'b0;
    end else begin
      read_latency_out <= lat.read_latency;
      write_latency_out <= lat.write_latency;
      latency_valid_out <= lat.valid;
      drive_strength_out <= drv_ohm;
      drive_valid_out <= drv_ok;
      derate_out <= (rate_r == 3'h6);
      over_85c_out <= rate_r[`MRS_HOT_BIT];
      temp_limit_out <= (rate_r == `MRS_RATE_COLD) ||
                        (rate_r == `MRS_RATE_HOT);
    end
  end

  // burst column sequencer
  mrs_burst_seq u_burst (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .burst_in(burst_in),
    .burst_length_in(burst_length_r),
    .burst_order_in(burst_order_r),
    .wrap_select_in(wrap_select_r),
    .col_out(col_out),
    .col_valid_out(col_valid_out),
    .illegal_out(burst_illegal_out)
  );

endmodule // mrs_mode_regs
`default_nettype wire

/* tb/mrs_mode_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrs_regs.svh"

// ----------------
// port checker
// ----------------
module mrs_mode_regs_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire mrs_pkg::mrs_cmd_t cmd_in,
  input wire mrs_pkg::mrs_burst_t burst_in,
  input wire logic [2:0] sensor_rate_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic [9:0] col_out,
  input wire logic col_valid_out,
  input wire logic burst_illegal_out,
  input wire logic [3:0] read_latency_out,
  input wire logic [2:0] write_latency_out,
  input wire logic latency_valid_out,
  input wire logic [6:0] drive_strength_out,
  input wire logic drive_valid_out,
  input wire logic derate_out,
  input wire logic over_85c_out,
  input wire logic temp_limit_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // register reads answer one cycle later
  read_answer_a: assert property (rd_valid_out == $past(cmd_in.rd))
    else $error("read answer mismatch");
  maker_id_a: assert property (cmd_in.rd &&
    cmd_in.mode_reg_index == `MRS_IDX_MAKER |=> rd_data_out == `MRS_MAKER_ID)
    else $error("maker code wrong");
  wo_read_a: assert property (cmd_in.rd &&
    cmd_in.mode_reg_index inside {8'h02, 8'h03} |=> rd_data_out == 8'h00)
    else $error("write-only register readable");
  temp_field_a: assert property (cmd_in.rd &&
    cmd_in.mode_reg_index == `MRS_IDX_TEMP |=> rd_data_out[6:3] == 4'h0
    && rd_data_out[2:0] != `MRS_RATE_RSVD)
    else $error("temperature field wrong");

  // decoded write-only registers
  lat_decode_a: assert property (cmd_in.wr &&
    cmd_in.mode_reg_index == `MRS_IDX_LATENCY &&
    cmd_in.opcode_bits[3:0] inside {[4'h1:4'h6]} |-> ##2 latency_valid_out
    && read_latency_out == $past(cmd_in.opcode_bits[3:0], 2) + 4'h2)
    else $error("latency decode wrong");
  lat_rsvd_a: assert property (cmd_in.wr &&
    cmd_in.mode_reg_index == `MRS_IDX_LATENCY &&
    !(cmd_in.opcode_bits[3:0] inside {[4'h1:4'h6]}) |-> ##2 !latency_valid_out)
    else $error("reserved latency taken as valid");
  drv_rsvd_a: assert property (cmd_in.wr &&
    cmd_in.mode_reg_index == `MRS_IDX_DRIVE &&
    cmd_in.opcode_bits[3:0] inside {4'h0, 4'h5, [4'h8:4'hf]}
    |-> ##2 !drive_valid_out)
    else $error("reserved drive taken as valid");
  drv_top_a: assert property (cmd_in.wr &&
    cmd_in.mode_reg_index == `MRS_IDX_DRIVE && cmd_in.opcode_bits[3:0] == 4'h7
    |-> ##2 drive_valid_out && drive_strength_out == 7'h78)
    else $error("drive code 7 wrong");

  // burst start handling
  burst_ack_a: assert property (burst_in.start |=>
    col_valid_out != burst_illegal_out)
    else $error("burst start not answered");
  col_first_a: assert property (burst_in.start ##1 col_valid_out |->
    col_out[9:1] == $past(burst_in.col[9:1]) && !col_out[0])
    else $error("first beat column wrong");
  illegal_pulse_a: assert property (burst_illegal_out |->
    $past(burst_in.start) && !col_valid_out)
    else $error("illegal flag without start");

  // temperature status levels agree
  derate_hot_a: assert property (derate_out |->
    over_85c_out && !temp_limit_out)
    else $error("derate without hot status");
endmodule // mrs_mode_regs_chk

bind mrs_mode_regs mrs_mode_regs_chk u_mrs_mode_regs_chk (.*);
`default_nettype wire

/* tb/mrs_host.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------
// controller model
// ----------------
module mrs_host (
  input wire logic clk_in,
  output var mrs_pkg::mrs_cmd_t cmd_out,
  output var mrs_pkg::mrs_burst_t burst_out
);
  logic [7:0] shadow [256];

  // idle lines at time zero
  initial begin
    cmd_out = '0;
    burst_out = '0;
  end

  // one command held across its sampling edge
  task automatic send(input logic [1:0] k, input logic [7:0] idx,
                      input logic [7:0] op);
    @(posedge clk_in);
    #1;
    cmd_out = {k, idx, op};
    @(posedge clk_in);
    #1;
    cmd_out = {2'h0, ~idx, ~op}; // released lines toggle
  endtask

  // writes keep a shadow copy
  task automatic mrw(input logic [7:0] idx, input logic [7:0] op);
    shadow[idx] = op;
    send(2'h2, idx, op);
  endtask

  // burst start held for its edge
  task automatic burst(input logic [9:0] col);
    @(posedge clk_in);
    #1;
    burst_out = {1'b1, col};
    @(posedge clk_in);
    #1;
    burst_out = {1'b0, ~col};
  endtask
endmodule // mrs_host
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrs_regs.svh"

module tb_top;
  logic clk_in;
  logic rst_b_in;
  logic [2:0] sensor_rate_in;
  mrs_pkg::mrs_cmd_t cmd_in;
  mrs_pkg::mrs_burst_t burst_in;
  logic [7:0] rd_data_out;
  logic rd_valid_out;
  logic [9:0] col_out;
  logic col_valid_out;
  logic burst_illegal_out;
  logic [3:0] read_latency_out;
  logic [2:0] write_latency_out;
  logic latency_valid_out;
  logic [6:0] drive_strength_out;
  logic drive_valid_out;
  logic derate_out;
  logic over_85c_out;
  logic temp_limit_out;
  int bad_count;
  int n_checks;
  logic [2:0] prev;
  logic [7:0] g;
  logic [23:0] r;
  // index, opcode, expected {decode, valid}
  logic [23:0] rows [18] = '{
    24'h02_0000, 24'h02_0133, 24'h02_0245, 24'h02_0355, 24'h02_0467,
    24'h02_0579, 24'h02_0689, 24'h02_0700, 24'h02_a355, 24'h03_0000,
    24'h03_0145, 24'h03_0251, 24'h03_0361, 24'h03_0479, 24'h03_0500,
    24'h03_06a1, 24'h03_07f1, 24'h03_0800};

  mrs_mode_regs u_mrs_mode_regs (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .cmd_in(cmd_in),
    .burst_in(burst_in),
    .sensor_rate_in(sensor_rate_in),
    .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out),
    .col_out(col_out),
    .col_valid_out(col_valid_out),
    .burst_illegal_out(burst_illegal_out),
    .read_latency_out(read_latency_out),
    .write_latency_out(write_latency_out),
    .latency_valid_out(latency_valid_out),
    .drive_strength_out(drive_strength_out),
    .drive_valid_out(drive_valid_out),
    .derate_out(derate_out),
    .over_85c_out(over_85c_out),
    .temp_limit_out(temp_limit_out)
  );
  mrs_host u_mrs_host (
    .clk_in(clk_in),
    .cmd_out(cmd_in),
    .burst_out(burst_in)
  );

  // ----------------
  // helpers
  // ----------------
  task automatic chk(input string nm, input logic [10:0] e,
                     input logic [10:0] got);
    n_checks++;
    if (got !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    u_mrs_host.send(2'h1, idx, 8'h00);
    chk("read", {3'h1, e}, {2'h0, rd_valid_out, rd_data_out});
  endtask

  // fe is {wrap_select, burst_order, burst_length}
  task automatic burst_chk(input logic [4:0] fe, input logic [9:0] col);
    int n;
    logic [9:0] c;
    logic [9:0] m;
    logic [9:0] e;
    n = (fe[2:0] inside {[3'h2:3'h4]}) ? 4 << (fe[2:0] - 3'h2) : 0;
    if ((fe[4] && n != 4) || (fe[3] && n == 16)) n = 0;
    u_mrs_host.mrw(8'h01, {3'h0, fe});
    repeat (2) @(posedge clk_in);
    u_mrs_host.burst(col);
    c = {col[9:1], 1'b0};
    m = 10'(n - 1);
    chk("illegal", 11'(n == 0), 11'(burst_illegal_out));
    for (int i = 0; i < n; i++) begin
      if (fe[4]) e = c + 10'(i);
      else if (fe[3]) e = c ^ 10'(i);
      else e = (c & ~m) | ((c + 10'(i)) & m);
      chk("beat", {1'b1, e}, {col_valid_out, col_out});
      @(posedge clk_in);
      #1;
    end
    chk("end", 11'h000, 11'(col_valid_out));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------
  // stimulus
  // ----------------
  // free running clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // run is far shorter than this limit
  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  // main sequence
  initial begin
    rst_b_in = 1'b0;
    sensor_rate_in = 3'h3;
    bad_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    for (int i = 0; i < 18; i++) begin
      r = rows[i];
      u_mrs_host.mrw(r[23:16], r[15:8]);
      repeat (2) @(posedge clk_in);
      #1;
      if (r[16]) g = {drive_strength_out, drive_valid_out};
      else g = {read_latency_out, write_latency_out, latency_valid_out};
      if (r[0]) chk("decode", {3'h0, r[7:0]}, {3'h0, g});
      else chk("reserved", 11'h000, 11'(g[0]));
    end
    $display("test decode done");
    rd_chk(`MRS_IDX_MAKER, `MRS_MAKER_ID);
    u_mrs_host.mrw(8'h05, 8'h00);
    rd_chk(8'h05, `MRS_MAKER_ID);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h07, 8'h00);
    u_mrs_host.mrw(8'h04, 8'h87);
    rd_chk(8'h04, 8'h03);
    $display("test reads done");
    prev = 3'h3;
    for (int c = 0; c < 8; c++) begin
      sensor_rate_in = 3'(c);
      repeat (5) @(posedge clk_in);
      #1;
      if (c != 4) prev = 3'(c);
      rd_chk(8'h04, {c != 4, 4'h0, prev});
      chk("status", {8'h00, prev == 3'h6, prev[2], prev == 3'h0 ||
        prev == 3'h7}, {8'h00, derate_out, over_85c_out, temp_limit_out});
      rd_chk(8'h04, {5'h00, prev});
    end
    $display("test temperature done");
    burst_chk(5'h04, 10'h3a7);
    burst_chk(5'h03, 10'h00d);
    burst_chk(5'h0b, 10'h006);
    burst_chk(5'h02, 10'h002);
    burst_chk(5'h12, 10'h00e);
    burst_chk(5'h0c, 10'h010);
    burst_chk(5'h14, 10'h020);
    burst_chk(5'h13, 10'h008);
    burst_chk(5'h07, 10'h004);
    $display("test bursts done");
    sensor_rate_in = 3'h3;
    repeat (5) @(posedge clk_in);
    #1;
    rst_b_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("rst", 11'h033, {3'h0, read_latency_out, write_latency_out,
      latency_valid_out});
    chk("rst", 11'h051, {3'h0, drive_strength_out, drive_valid_out});
    rst_b_in = 1'b1;
    rd_chk(8'h04, 8'h03);
    $display("test reset done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
